// >>> inc/mmc_regs.svh
`ifndef MMC_REGS_SVH
`define MMC_REGS_SVH

// Register indices; the byte address on the bus is four times the index
`define MMC_IDX_PAGE 6'h30
`define MMC_IDX_DIRECT 6'h31
`define MMC_IDX_MODE 6'h32
`define MMC_IDX_CTL 6'h33

// Reset values
`define MMC_PAGE_RST 8'hfe
`define MMC_DIRECT_RST 8'h00
`define MMC_CTL_RST 8'h00

// Field positions
`define MMC_MODE_BIT 7
`define MMC_INFO_BIT 0
`define MMC_PAGE_UPPER 4'hf

// Fixed pages of the unpaged local regions
`define MMC_PAGE_LOW 8'hfc
`define MMC_PAGE_MID 8'hfd
`define MMC_PAGE_TOP 8'hff

// Global windows
`define MMC_IDENT_TOP 16'h07ff
`define MMC_INFO_LO 16'h0400
`define MMC_INFO_HI 16'h047f

// Bus answers
`define MMC_RESP_OKAY 2'h0
`define MMC_RESP_SLVERR 2'h2

`endif

// >>> inc/mmc_pkg.sv
package mmc_pkg;

  // Bus channel state, one-hot
  typedef enum logic [1:0] {
    HS_IDLE = 2'b01,
    HS_RESP = 2'b10
  } handshake_state_t;

  // Mode bit encoding: 1 normal single-chip, 0 special single-chip
  typedef enum logic {
    MODE_SPECIAL = 1'b0,
    MODE_NORMAL = 1'b1
  } op_mode_t;

endpackage : mmc_pkg

// >>> inc/map_if.sv
interface map_if;
  logic [15:0] local_addr;
  logic direct_mode;
  logic [3:0] page;
  logic [7:0] direct_base;
  logic info_on;
  logic [17:0] global_addr;
  logic info_hit;

  modport req (
    output local_addr,
    output direct_mode,
    output page,
    output direct_base,
    output info_on,
    input global_addr,
    input info_hit
  );

  modport map (
    input local_addr,
    input direct_mode,
    input page,
    input direct_base,
    input info_on,
    output global_addr,
    output info_hit
  );
endinterface : map_if

// >>> verilog/addr_map.sv
`include "mmc_regs.svh"

module addr_map (
  input wire logic clk,
  input wire logic resetn,
  map_if.map m
);

  logic [15:0] eff_addr;
  logic [7:0] sel_page;
  logic ident_hit;
  logic info_d;
  logic [17:0] global_d;
  logic [17:0] global_q;
  logic info_q;

  ////////////////////////////////////////////////////////////////////////
  // Direct mode takes the upper byte from the direct page base [RULE_08]
  assign eff_addr = m.direct_mode ? {m.direct_base, m.local_addr[7:0]} : m.local_addr;

  // Fixed regions ignore the page register; the window uses it [RULE_02] [RULE_04]
  assign sel_page = (eff_addr[15:14] == 2'b00) ? `MMC_PAGE_LOW :
                    (eff_addr[15:14] == 2'b01) ? `MMC_PAGE_MID :
                    (eff_addr[15:14] == 2'b10) ? {`MMC_PAGE_UPPER, m.page} :
                    `MMC_PAGE_TOP;

  // Register and info-row space keeps its global address unchanged
  assign ident_hit = (eff_addr <= `MMC_IDENT_TOP);
  assign info_d = m.info_on && (eff_addr >= `MMC_INFO_LO) && (eff_addr <= `MMC_INFO_HI); // [RULE_15]
  // Page bits sit above the low fourteen address bits [RULE_06]
  assign global_d = ident_hit ? {2'b00, eff_addr} : {sel_page[3:0], eff_addr[13:0]};

  // Registered result, one cycle behind the request
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      global_q <= 18'h00000;
      info_q <= 1'b0;
    end else begin
      global_q <= global_d;
      info_q <= info_d;
    end
  end

  assign m.global_addr = global_q;
  assign m.info_hit = info_q;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_window_page;
    (!m.direct_mode && m.local_addr[15:14] == 2'b10)
      |=> m.global_addr[17:14] == $past(m.page) && m.global_addr[13:0] == $past(m.local_addr[13:0]);
  endproperty
  a_window_page: assert property (p_window_page) else $error("Window page wrong"); // [RULE_02]

  property p_top_fixed;
    (!m.direct_mode && m.local_addr[15:14] == 2'b11) |=> m.global_addr[17:14] == 4'hf;
  endproperty
  a_top_fixed: assert property (p_top_fixed) else $error("Top region not page ff"); // [RULE_04]

  property p_mid_fixed;
    (!m.direct_mode && m.local_addr[15:14] == 2'b01) |=> m.global_addr[17:14] == 4'hd;
  endproperty
  a_mid_fixed: assert property (p_mid_fixed) else $error("Mid region not page fd"); // [RULE_04]

  property p_direct_upper;
    (m.direct_mode && m.direct_base[7:6] == 2'b10)
      |=> m.global_addr[13:8] == $past(m.direct_base[5:0]);
  endproperty
  a_direct_upper: assert property (p_direct_upper) else $error("Direct base unused"); // [RULE_08]

  property p_info_gate;
    m.info_hit |-> $past(m.info_on) && m.global_addr[17:7] == 11'h008;
  endproperty
  a_info_gate: assert property (p_info_gate) else $error("Info row shown wrongly"); // [RULE_15]

  c_info_hit: cover property (m.info_hit);

endmodule : addr_map

// >>> verilog/memory_map_mode_control.sv
// How it works
// [RULE_01] Page register reads ones above four index bits, resets to fe.
// [RULE_02] Local 8000-bfff window maps onto the selected flash page for both masters.
// [RULE_03] Call and return path loads the page register within one cycle.
// [RULE_04] Low, middle and top local regions use fixed pages fc, fd, ff.
// [RULE_05] Reset page fe makes the whole local space linear flash.
// [RULE_06] Global address is page index bits above fourteen local bits.
// [RULE_07] Direct base resets zero; normal mode takes only its first write.
// [RULE_08] Direct addressing takes address bits 15 to 8 from direct base.
// [RULE_09] Mode bit in bit 7, rest zero, captured from pin after reset.
// [RULE_10] Mode follows the pin in reset and the stored bit afterwards.
// [RULE_11] Outside logic holds the mode pin steady while reset is low.
// [RULE_12] Refused mode write keeps the bit and locks writes outside special mode.
// [RULE_13] Special to normal is allowed; normal to special is refused.
// [RULE_14] While secured every mode change is refused.
// [RULE_15] Info-row bit 0 shows the info row at global 00400-0047f.
// [RULE_16] Normal mode offers no external bus and refuses external accesses.
// [RULE_17] Special mode hands execution to background debug control.
//
// Decided for this implementation: the AXI4-Lite register port.
`include "mmc_regs.svh"

module memory_map_mode_control #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic mode_select_pin,
  input wire logic secured,
  input wire logic page_load,
  input wire logic [3:0] page_load_data,
  output logic [3:0] page_index_bits,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_direct,
  output logic [17:0] cpu_global_addr,
  output logic cpu_info_hit,
  input wire logic [15:0] dbg_addr,
  input wire logic dbg_direct,
  output logic [17:0] dbg_global_addr,
  output logic dbg_info_hit,
  output logic special_mode,
  output logic debug_control,
  input wire logic ext_access_req,
  output logic ext_access_err,
  output logic ext_bus_enable
);

  ////////////////////////////////////////////////////////////////////////
  // Register decode helper
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [5:0] idx);
    reg_hit = (addr == ADDR_W'({idx, 2'b00}));
  endfunction : reg_hit

  mmc_pkg::handshake_state_t wr_state_q;
  mmc_pkg::handshake_state_t wr_state_d;
  mmc_pkg::handshake_state_t rd_state_q;
  mmc_pkg::handshake_state_t rd_state_d;
  logic aw_have_q;
  logic w_have_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  logic [1:0] bresp_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [3:0] page_q;
  logic [7:0] direct_q;
  logic direct_done_q;
  logic mode_q;
  logic captured_q;
  logic mode_lock_q;
  logic info_q;

  logic aw_take;
  logic w_take;
  logic do_write;
  logic ar_take;
  logic wr_page;
  logic wr_direct;
  logic wr_mode;
  logic wr_ctl;
  logic wr_mapped;
  logic rd_mapped;
  logic op_mode;
  logic is_special;
  logic mode_new;
  logic mode_allowed;
  logic mode_refused;
  logic mode_apply;
  logic direct_apply;
  logic [7:0] rd_byte;

  ////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order
  assign s_axi_awready = (wr_state_q == mmc_pkg::HS_IDLE) && !aw_have_q;
  assign s_axi_wready = (wr_state_q == mmc_pkg::HS_IDLE) && !w_have_q;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign do_write = (wr_state_q == mmc_pkg::HS_IDLE) && aw_have_q && w_have_q;
  assign s_axi_bvalid = (wr_state_q == mmc_pkg::HS_RESP);
  assign s_axi_bresp = bresp_q;

  // Write state sequencing
  always_comb begin
    wr_state_d = wr_state_q;
    case (wr_state_q)
      mmc_pkg::HS_IDLE: if (do_write) wr_state_d = mmc_pkg::HS_RESP;
      mmc_pkg::HS_RESP: if (s_axi_bready) wr_state_d = mmc_pkg::HS_IDLE;
      default: wr_state_d = mmc_pkg::HS_IDLE;
    endcase
  end

  // Capture of write address and data
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_state_q <= mmc_pkg::HS_IDLE;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
      bresp_q <= `MMC_RESP_OKAY;
    end else begin
      wr_state_q <= wr_state_d;
      if (aw_take) awaddr_q <= s_axi_awaddr;
      if (w_take) wbyte_q <= s_axi_wdata[7:0];
      if (w_take) wlane_q <= s_axi_wstrb[0];
      aw_have_q <= do_write ? 1'b0 : (aw_have_q | aw_take);
      w_have_q <= do_write ? 1'b0 : (w_have_q | w_take);
      if (do_write) bresp_q <= wr_mapped ? `MMC_RESP_OKAY : `MMC_RESP_SLVERR;
    end
  end

  // Writes touch only byte lane 0; unmapped writes answer with an error
  assign wr_page = do_write && wlane_q && reg_hit(awaddr_q, `MMC_IDX_PAGE);
  assign wr_direct = do_write && wlane_q && reg_hit(awaddr_q, `MMC_IDX_DIRECT);
  assign wr_mode = do_write && wlane_q && reg_hit(awaddr_q, `MMC_IDX_MODE);
  assign wr_ctl = do_write && wlane_q && reg_hit(awaddr_q, `MMC_IDX_CTL);
  assign wr_mapped = reg_hit(awaddr_q, `MMC_IDX_PAGE) || reg_hit(awaddr_q, `MMC_IDX_DIRECT) ||
                     reg_hit(awaddr_q, `MMC_IDX_MODE) || reg_hit(awaddr_q, `MMC_IDX_CTL);

  ////////////////////////////////////////////////////////////////////////
  // Operating mode: pin during reset and until captured, stored bit after
  assign op_mode = (resetn && captured_q) ? mode_q : mode_select_pin; // [RULE_10]
  assign is_special = (op_mode == mmc_pkg::MODE_SPECIAL);
  assign special_mode = is_special;
  assign debug_control = is_special; // [RULE_17]
  // No external bus in either single-chip mode
  assign ext_bus_enable = 1'b0; // [RULE_16]
  assign ext_access_err = ext_access_req; // [RULE_16]

  // Mode write legality; equal value is a harmless no-change write
  assign mode_new = wbyte_q[`MMC_MODE_BIT];
  assign mode_allowed = (mode_new == mode_q) ||
                        (mode_q == mmc_pkg::MODE_SPECIAL && mode_new == mmc_pkg::MODE_NORMAL); // [RULE_13]
  assign mode_refused = wr_mode && (mode_new != mode_q) && (!mode_allowed || secured); // [RULE_12] [RULE_14]
  assign mode_apply = wr_mode && !mode_refused && (!mode_lock_q || is_special); // [RULE_12]
  // Direct base: any write in special mode; in normal mode only if it is the first direct write since reset
  assign direct_apply = wr_direct && (is_special || !direct_done_q); // [RULE_07]

  // Mode capture happens on the first clock after reset release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      captured_q <= 1'b0;
      mode_q <= 1'b0;
      mode_lock_q <= 1'b0;
    end else begin
      captured_q <= 1'b1;
      if (!captured_q) mode_q <= mode_select_pin; // [RULE_09]
      else if (mode_apply) mode_q <= mode_new; // [RULE_13]
      if (mode_refused) mode_lock_q <= 1'b1; // [RULE_12]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mapping registers; call/return path wins over a bus write
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      page_q <= 4'(`MMC_PAGE_RST); // [RULE_01] [RULE_05]
      direct_q <= `MMC_DIRECT_RST; // [RULE_07]
      direct_done_q <= 1'b0;
      info_q <= 1'(`MMC_CTL_RST);
    end else begin
      if (page_load) page_q <= page_load_data; // [RULE_03]
      else if (wr_page) page_q <= wbyte_q[3:0]; // [RULE_01]
      if (direct_apply) direct_q <= wbyte_q; // [RULE_07]
      if (wr_direct) direct_done_q <= 1'b1;
      if (wr_ctl) info_q <= wbyte_q[`MMC_INFO_BIT]; // [RULE_15]
    end
  end

  assign page_index_bits = page_q;

  ////////////////////////////////////////////////////////////////////////
  // Read channel: one outstanding read, data from a register
  assign s_axi_arready = (rd_state_q == mmc_pkg::HS_IDLE);
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign s_axi_rvalid = (rd_state_q == mmc_pkg::HS_RESP);
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign rd_mapped = reg_hit(s_axi_araddr, `MMC_IDX_PAGE) || reg_hit(s_axi_araddr, `MMC_IDX_DIRECT) ||
                     reg_hit(s_axi_araddr, `MMC_IDX_MODE) || reg_hit(s_axi_araddr, `MMC_IDX_CTL);
  // Read mux; upper and reserved bits are constants
  assign rd_byte = reg_hit(s_axi_araddr, `MMC_IDX_PAGE) ? {`MMC_PAGE_UPPER, page_q} : // [RULE_01]
                   reg_hit(s_axi_araddr, `MMC_IDX_DIRECT) ? direct_q :
                   reg_hit(s_axi_araddr, `MMC_IDX_MODE) ? {mode_q, 7'h00} : // [RULE_09]
                   reg_hit(s_axi_araddr, `MMC_IDX_CTL) ? {7'h00, info_q} : 8'h00;

  // Read state sequencing
  always_comb begin
    rd_state_d = rd_state_q;
    case (rd_state_q)
      mmc_pkg::HS_IDLE: if (ar_take) rd_state_d = mmc_pkg::HS_RESP;
      mmc_pkg::HS_RESP: if (s_axi_rready) rd_state_d = mmc_pkg::HS_IDLE;
      default: rd_state_d = mmc_pkg::HS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_state_q <= mmc_pkg::HS_IDLE;
      rdata_q <= 32'h00000000;
      rresp_q <= `MMC_RESP_OKAY;
    end else begin
      rd_state_q <= rd_state_d;
      if (ar_take) rdata_q <= {24'h000000, rd_byte};
      if (ar_take) rresp_q <= rd_mapped ? `MMC_RESP_OKAY : `MMC_RESP_SLVERR;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // One mapper per master; both share page, direct base and info bit
  map_if cpu_m ();
  map_if dbg_m ();

  assign cpu_m.local_addr = cpu_addr;
  assign cpu_m.direct_mode = cpu_direct;
  assign cpu_m.page = page_q;
  assign cpu_m.direct_base = direct_q;
  assign cpu_m.info_on = info_q;
  assign dbg_m.local_addr = dbg_addr;
  assign dbg_m.direct_mode = dbg_direct;
  assign dbg_m.page = page_q;
  assign dbg_m.direct_base = direct_q;
  assign dbg_m.info_on = info_q;

  addr_map u_cpu_map (
    .clk(clk),
    .resetn(resetn),
    .m(cpu_m.map)
  );

  addr_map u_dbg_map (
    .clk(clk),
    .resetn(resetn),
    .m(dbg_m.map)
  );

  assign cpu_global_addr = cpu_m.global_addr;
  assign cpu_info_hit = cpu_m.info_hit;
  assign dbg_global_addr = dbg_m.global_addr;
  assign dbg_info_hit = dbg_m.info_hit;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_page_read_ones;
    (ar_take && reg_hit(s_axi_araddr, `MMC_IDX_PAGE)) |=> s_axi_rvalid && s_axi_rdata[7:4] == 4'hf;
  endproperty
  a_page_read_ones: assert property (p_page_read_ones) else $error("Page upper bits not ones"); // [RULE_01]

  property p_page_reset;
    !captured_q |-> page_q == 4'he;
  endproperty
  a_page_reset: assert property (p_page_reset) else $error("Page reset value wrong"); // [RULE_05]

  property p_call_path;
    page_load |=> page_q == $past(page_load_data);
  endproperty
  a_call_path: assert property (p_call_path) else $error("Call path update late"); // [RULE_03]

  property p_direct_once;
    (wr_direct && !is_special && direct_done_q) |=> $stable(direct_q);
  endproperty
  a_direct_once: assert property (p_direct_once) else $error("Second direct write taken"); // [RULE_07]

  property p_mode_capture;
    $rose(captured_q) |-> mode_q == $past(mode_select_pin);
  endproperty
  a_mode_capture: assert property (p_mode_capture) else $error("Mode pin not captured"); // [RULE_09]

  property p_no_ns_to_ss;
    (captured_q && mode_q == mmc_pkg::MODE_NORMAL) |=> mode_q == mmc_pkg::MODE_NORMAL;
  endproperty
  a_no_ns_to_ss: assert property (p_no_ns_to_ss) else $error("Normal to special allowed"); // [RULE_13]

  property p_secured;
    (wr_mode && secured && captured_q) |=> $stable(mode_q);
  endproperty
  a_secured: assert property (p_secured) else $error("Mode changed while secured"); // [RULE_14]

  property p_lock;
    (mode_lock_q && !is_special && wr_mode) |=> $stable(mode_q);
  endproperty
  a_lock: assert property (p_lock) else $error("Locked mode bit written"); // [RULE_12]

  property p_mode_follows;
    captured_q |-> special_mode == (mode_q == mmc_pkg::MODE_SPECIAL);
  endproperty
  a_mode_follows: assert property (p_mode_follows) else $error("Mode not from stored bit"); // [RULE_10]

  property p_ext_refused;
    ext_access_req |-> ext_access_err && !ext_bus_enable;
  endproperty
  a_ext_refused: assert property (p_ext_refused) else $error("External access not refused"); // [RULE_16]

  property p_write_answer;
    do_write |=> s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("No write response");

  c_mode_ss_to_ns: cover property (captured_q && mode_q == 1'b0 ##1 mode_q == 1'b1);
  c_mode_refused: cover property (mode_refused);
  c_direct_ignored: cover property (wr_direct && !direct_apply);
  c_call_and_bus: cover property (page_load && wr_page);

endmodule : memory_map_mode_control

// >>> tb/master_model.sv
// Far side of the mapper: CPU and debug master address buses
module master_model (
  input wire logic clk,
  output logic [15:0] cpu_addr,
  output logic cpu_direct,
  output logic [15:0] dbg_addr,
  output logic dbg_direct,
  output logic page_load,
  output logic [3:0] page_load_data
);
  timeunit 1ns;
  timeprecision 100ps;

  ////////////////////////////////////////////////////////////////////////////
  // Idle bus at time zero
  initial begin
    cpu_addr = 16'h0000;
    cpu_direct = 1'b0;
    dbg_addr = 16'h0000;
    dbg_direct = 1'b0;
    page_load = 1'b0;
    page_load_data = 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Both masters present the same address, so both map paths are compared
  task automatic present(input logic [15:0] a, input logic dm);
    @(posedge clk);
    cpu_addr <= a;
    cpu_direct <= dm;
    dbg_addr <= a;
    dbg_direct <= dm;
  endtask : present

  // Call/return page switch: one-cycle strobe, done well before the instruction ends
  task automatic call_page(input logic [3:0] p);
    @(posedge clk);
    page_load <= 1'b1;
    page_load_data <= p;
    @(posedge clk);
    page_load <= 1'b0;
  endtask : call_page
endmodule : master_model

// >>> tb/memory_map_mode_control_bench.sv
`include "mmc_regs.svh"

module memory_map_mode_control_bench;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [1:0] rsp_ok = `MMC_RESP_OKAY;
  localparam logic [1:0] rsp_err = `MMC_RESP_SLVERR;

  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic mode_pin = 1'b0;
  logic secured = 1'b0;
  logic ext_req = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] cpu_addr, dbg_addr;
  logic cpu_direct, dbg_direct, page_load, cpu_hit, dbg_hit;
  logic [3:0] page_load_data, page_idx;
  logic [17:0] cpu_ga, dbg_ga;
  logic special, dbg_ctl, ext_err, ext_en;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  memory_map_mode_control u_dut (
    .clk(clk), .resetn(resetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .mode_select_pin(mode_pin), .secured(secured),
    .page_load(page_load), .page_load_data(page_load_data), .page_index_bits(page_idx),
    .cpu_addr(cpu_addr), .cpu_direct(cpu_direct), .cpu_global_addr(cpu_ga),
    .cpu_info_hit(cpu_hit), .dbg_addr(dbg_addr), .dbg_direct(dbg_direct),
    .dbg_global_addr(dbg_ga), .dbg_info_hit(dbg_hit), .special_mode(special),
    .debug_control(dbg_ctl), .ext_access_req(ext_req), .ext_access_err(ext_err),
    .ext_bus_enable(ext_en)
  );

  master_model u_mst (
    .clk(clk), .cpu_addr(cpu_addr), .cpu_direct(cpu_direct), .dbg_addr(dbg_addr),
    .dbg_direct(dbg_direct), .page_load(page_load), .page_load_data(page_load_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Closing report and comparison helper
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Hang guard: the whole sequence needs under 150 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      bad_count++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus master: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    check({30'h0, bresp}, {30'h0, er});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    check(rdata, exp);
    check({30'h0, rresp}, {30'h0, er});
  endtask : rd

  // Mapped output lands one edge after the address, so look on the second
  task automatic map_chk(input logic [15:0] a, input logic dm, input logic [17:0] ega,
                         input logic eh);
    u_mst.present(a, dm);
    repeat (2) @(posedge clk);
    check({14'h0, cpu_ga}, {14'h0, ega});
    check({14'h0, dbg_ga}, {14'h0, ega});
    check({31'h0, cpu_hit}, {31'h0, eh});
    check({31'h0, dbg_hit}, {31'h0, eh});
  endtask : map_chk

  ////////////////////////////////////////////////////////////////////////////
  // Special start, mode handover, then a normal start with the mapping checks
  initial begin
    repeat (8) @(posedge clk);
    check({31'h0, special}, 32'h1);
    check({31'h0, dbg_ctl}, 32'h1);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    mode_pin <= 1'b1;
    repeat (2) @(posedge clk);
    check({31'h0, special}, 32'h1);
    rd(8'hc8, 32'h0, rsp_ok);
    wr(8'hc4, 8'h12, rsp_ok);
    wr(8'hc4, 8'h34, rsp_ok);
    rd(8'hc4, 32'h34, rsp_ok);
    secured <= 1'b1;
    wr(8'hc8, 8'h80, rsp_ok);
    rd(8'hc8, 32'h0, rsp_ok);
    secured <= 1'b0;
    wr(8'hc8, 8'h80, rsp_ok);
    rd(8'hc8, 32'h80, rsp_ok);
    check({31'h0, special}, 32'h0);
    check({31'h0, dbg_ctl}, 32'h0);
    ext_req <= 1'b1;
    @(posedge clk);
    check({31'h0, ext_err}, 32'h1);
    check({31'h0, ext_en}, 32'h0);
    wr(8'hc8, 8'h00, rsp_ok);
    rd(8'hc8, 32'h80, rsp_ok);
    wr(8'hc4, 8'h56, rsp_ok);
    rd(8'hc4, 32'h34, rsp_ok);
    // Pin high and steady across the whole second reset
    resetn <= 1'b0;
    repeat (8) @(posedge clk);
    check({31'h0, special}, 32'h0);
    resetn <= 1'b1;
    @(posedge clk);
    rd(8'hc0, 32'hfe, rsp_ok);
    rd(8'hc4, 32'h0, rsp_ok);
    rd(8'hc8, 32'h80, rsp_ok);
    rd(8'hcc, 32'h0, rsp_ok);
    map_chk(16'h8000, 1'b0, 18'h38000, 1'b0);
    map_chk(16'h3000, 1'b0, 18'h33000, 1'b0);
    map_chk(16'h4000, 1'b0, 18'h34000, 1'b0);
    map_chk(16'hc005, 1'b0, 18'h3c005, 1'b0);
    wr(8'hc4, 8'h80, rsp_ok);
    wr(8'hc4, 8'h22, rsp_ok);
    rd(8'hc4, 32'h80, rsp_ok);
    map_chk(16'h0010, 1'b1, 18'h38010, 1'b0);
    wr(8'hc0, 8'h03, rsp_ok);
    rd(8'hc0, 32'hf3, rsp_ok);
    map_chk(16'h8123, 1'b0, 18'h0c123, 1'b0);
    map_chk(16'hbfff, 1'b0, 18'h0ffff, 1'b0);
    u_mst.call_page(4'h5);
    @(posedge clk);
    check({28'h0, page_idx}, 32'h5);
    rd(8'hc0, 32'hf5, rsp_ok);
    wr(8'hcc, 8'h01, rsp_ok);
    map_chk(16'h0410, 1'b0, 18'h00410, 1'b1);
    wr(8'hcc, 8'h00, rsp_ok);
    map_chk(16'h047f, 1'b0, 18'h0047f, 1'b0);
    // Unmapped places answer with an error
    wr(8'hd0, 8'h01, rsp_err);
    rd(8'h10, 32'h0, rsp_err);
    give_verdict();
  end
endmodule : memory_map_mode_control_bench
